// file: design/msr_pkg.sv
// constants, field layout and carrier types of the monitor status registers
package msr_pkg;

    // ==========================================================
    // bus geometry
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int BE_W   = 4;

    // ==========================================================
    // register indices; the byte address is four times the index
    localparam logic [5:0] IDX_STATUS4  = 6'h23;
    localparam logic [5:0] IDX_STATUS5  = 6'h24;
    localparam logic [5:0] IDX_PINCFG1  = 6'h30;
    localparam logic [5:0] IDX_PINCFG2  = 6'h31;
    localparam logic [5:0] IDX_PIN16CFG = 6'h32;
    localparam logic [5:0] IDX_IRQ_STAT = 6'h33;
    localparam logic [5:0] IDX_IRQ_MASK = 6'h34;

    // ==========================================================
    // status four bit positions
    localparam int ST4_INT_TEMP  = 0;
    localparam int ST4_BATTERY   = 1;
    localparam int ST4_ANALOG_INPUT_EIGHT      = 2;
    localparam int ST4_THERMAL   = 3;
    localparam int ST4_FAN       = 4;
    localparam int ST4_INTRUSION = 6;
    localparam int ST4_PIN16     = 7;
    localparam int LIMIT_W       = 3;

    // ==========================================================
    // pins, configuration layout and reset values
    localparam int NUM_PINS    = 9;
    localparam int PIN16_POS   = 8;
    localparam int PINS_PER_CFG = 4;
    localparam int CFG_DIR_OFS = 0;
    localparam int CFG_POL_OFS = 1;
    localparam logic [7:0] REG8_RESET = 8'h00;

    // ==========================================================
    // interrupt status and mask layout
    localparam int IRQ_W         = 4;
    localparam int IRQ_INT_THERMAL_LIMIT_MODE = 0;
    localparam int IRQ_ANY_THERMAL_LIMIT_MODE = 1;
    localparam int IRQ_FAN       = 2;
    localparam int IRQ_INTRUSION = 3;

    // avalon request as the master presents it
    typedef struct packed {
        logic              read;
        logic              write;
        logic [ADDR_W-1:0] address;
        logic [DATA_W-1:0] writedata;
        logic [BE_W-1:0]   byteenable;
    } msr_avmm_req_type;

    // levels from the conversion and fan control logic
    typedef struct packed {
        logic [LIMIT_W-1:0] out_of_limit;
        logic               int_thermal_mode;
        logic               any_thermal_mode;
        logic               automatic_fan_control;
        logic               fan_running;
    } msr_monitor_type;

endpackage : msr_pkg

// file: design/msr_status_regs.sv
// status registers four and five with pin logic and avalon slave
`timescale 1ns/1ps

// ==========================================================
module msr_status_regs (
    // clock and reset
    input  wire logic                     clk_i,
    input  wire logic                     reset_n_i,
    // avalon slave
    input  wire msr_pkg::msr_avmm_req_type avm_i,
    output logic [msr_pkg::DATA_W-1:0]    avm_readdata_o,
    output logic                          avm_waitrequest_o,
    // monitor core
    input  wire logic                     conv_done_i,
    input  wire msr_pkg::msr_monitor_type monitor_i,
    // pins
    input  wire logic                     chassis_intrusion_i,
    input  wire logic [msr_pkg::NUM_PINS-1:0] gpio_in_i,
    output logic [msr_pkg::NUM_PINS-1:0]  gpio_out_o,
    output logic [msr_pkg::NUM_PINS-1:0]  gpio_oe_o,
    // interrupt
    output logic                          irq_o
);
    import msr_pkg::*;

    // picks one bit of a direction/polarity pair for pin n of a config byte
    function automatic logic pair_bit(input logic [7:0] cfg,
                                      input int n, input int ofs);
        pair_bit = cfg[2 * (n % PINS_PER_CFG) + ofs];
    endfunction : pair_bit

    // byte address of a register index
    function automatic logic [ADDR_W-1:0] byte_addr(input logic [5:0] idx);
        byte_addr = {idx, 2'b00};
    endfunction : byte_addr

    // ==========================================================
    // state
    logic                wait_reg;
    logic [DATA_W-1:0]   rdata_reg;
    logic [7:0]          pincfg1_reg;
    logic [7:0]          pincfg2_reg;
    logic [7:0]          pin16cfg_reg;
    logic [IRQ_W-1:0]    irq_stat_reg;
    logic [IRQ_W-1:0]    irq_mask_reg;
    logic                irq_reg;
    logic [LIMIT_W-1:0]  limit_reg;
    logic                int_ev_reg;
    logic                thermal_limit_mode_ev_reg;
    logic                fan_ev_reg;
    logic                intrusion_reg;
    logic [NUM_PINS-1:0] out_bit_reg;
    logic [NUM_PINS-1:0] gpio_out_reg;
    logic [NUM_PINS-1:0] gpio_oe_reg;
    logic                int_mode_reg;
    logic                any_mode_reg;
    logic                fan_reg;
    logic [NUM_PINS-1:0] pin_meta_reg;
    logic [NUM_PINS-1:0] pin_sync_reg;
    logic                ci_meta_reg;
    logic                ci_sync_reg;
    logic                ci_prev_reg;

    // ==========================================================
    // bus decode: request is taken on the edge where wait is low
    logic        rd_done;
    logic        wr_done;
    logic        wr_b0;
    logic        sel_st4;
    logic        sel_st5;
    logic        sel_cfg1;
    logic        sel_cfg2;
    logic        sel_cfg16;
    logic        sel_istat;
    logic        sel_imask;
    logic [7:0]  wbyte;
    assign rd_done   = avm_i.read & ~wait_reg;
    assign wr_done   = avm_i.write & ~wait_reg;
    assign wr_b0     = wr_done & avm_i.byteenable[0];
    assign wbyte     = avm_i.writedata[7:0];
    assign sel_st4   = avm_i.address == byte_addr(IDX_STATUS4);
    assign sel_st5   = avm_i.address == byte_addr(IDX_STATUS5);
    assign sel_cfg1  = avm_i.address == byte_addr(IDX_PINCFG1);
    assign sel_cfg2  = avm_i.address == byte_addr(IDX_PINCFG2);
    assign sel_cfg16 = avm_i.address == byte_addr(IDX_PIN16CFG);
    assign sel_istat = avm_i.address == byte_addr(IDX_IRQ_STAT);
    assign sel_imask = avm_i.address == byte_addr(IDX_IRQ_MASK);

    // ==========================================================
    // per-pin direction (1 = output) and polarity (1 = active high)
    logic [NUM_PINS-1:0] pin_dir;
    logic [NUM_PINS-1:0] pin_pol;
    logic [NUM_PINS-1:0] pin_asserted;
    logic [NUM_PINS-1:0] pin_view;
    for (genvar p = 0; p < PINS_PER_CFG; p++) begin : g_cfg
        assign pin_pol[p] = pair_bit(pincfg1_reg, p, CFG_POL_OFS);
        assign pin_dir[p] = pair_bit(pincfg1_reg, p, CFG_DIR_OFS);
        assign pin_pol[p+PINS_PER_CFG] =
            pair_bit(pincfg2_reg, p, CFG_POL_OFS);
        assign pin_dir[p+PINS_PER_CFG] =
            pair_bit(pincfg2_reg, p, CFG_DIR_OFS);
    end
    assign pin_pol[PIN16_POS] = pair_bit(pin16cfg_reg, 0, CFG_POL_OFS);
    assign pin_dir[PIN16_POS] = pair_bit(pin16cfg_reg, 0, CFG_DIR_OFS);
    assign pin_asserted = pin_sync_reg ~^ pin_pol;
    // inputs show pin state, outputs show the written bit
    assign pin_view = (pin_dir & out_bit_reg) | (~pin_dir & pin_asserted);

    // ==========================================================
    // transition pulses and event sources
    logic int_edge;
    logic any_edge;
    logic fan_edge;
    logic ci_rise;
    logic [IRQ_W-1:0] irq_set;
    assign int_edge = monitor_i.int_thermal_mode ^ int_mode_reg;
    assign any_edge = monitor_i.any_thermal_mode ^ any_mode_reg;
    assign fan_edge = monitor_i.automatic_fan_control
                    & (monitor_i.fan_running ^ fan_reg);
    assign ci_rise  = ci_sync_reg & ~ci_prev_reg;
    assign irq_set  = {ci_rise, fan_edge, any_edge, int_edge};

    // ==========================================================
    // read view of status four
    logic [7:0] st4_view;
    logic [7:0] st5_view;
    logic       rd_st4_clr;
    // bit five is wired to zero
    assign st4_view = {pin_view[PIN16_POS], intrusion_reg, 1'b0,
                       fan_ev_reg, thermal_limit_mode_ev_reg, limit_reg[ST4_ANALOG_INPUT_EIGHT],
                       limit_reg[ST4_BATTERY],
                       limit_reg[ST4_INT_TEMP] | int_ev_reg};
    assign st5_view = pin_view[7:0];
    // read of status four clears only the event bits it reported
    assign rd_st4_clr = rd_done & sel_st4;

    // read data mux, unmapped addresses read zero
    logic [7:0] rd_byte;
    assign rd_byte = sel_st4   ? st4_view :
                     sel_st5   ? st5_view :
                     sel_cfg1  ? pincfg1_reg :
                     sel_cfg2  ? pincfg2_reg :
                     sel_cfg16 ? pin16cfg_reg :
                     sel_istat ? {4'h0, irq_stat_reg} :
                     sel_imask ? {4'h0, irq_mask_reg} : 8'h00;

    // ==========================================================
    // next values
    logic [NUM_PINS-1:0] out_bit_next;
    logic [IRQ_W-1:0]    irq_stat_next;
    logic                int_ev_next;
    logic                thermal_limit_mode_ev_next;
    logic                fan_ev_next;
    logic                intrusion_next;
    // a status write lands only on pins set as outputs
    assign out_bit_next[7:0] = (wr_b0 & sel_st5)
        ? (pin_dir[7:0] & wbyte) | (~pin_dir[7:0] & out_bit_reg[7:0])
        : out_bit_reg[7:0];
    // pin sixteen written through status four bit 7
    assign out_bit_next[PIN16_POS] =
        (wr_b0 & sel_st4 & pin_dir[PIN16_POS])
        ? wbyte[ST4_PIN16] : out_bit_reg[PIN16_POS];
    // sticky flags: a new event wins over the clear
    // internal and any thermal engage and release
    assign int_ev_next = (int_ev_reg
        & ~(rd_st4_clr & rdata_reg[ST4_INT_TEMP])) | int_edge;
    assign thermal_limit_mode_ev_next = (thermal_limit_mode_ev_reg
        & ~(rd_st4_clr & rdata_reg[ST4_THERMAL])) | any_edge;
    // fan start and stop under automatic control
    assign fan_ev_next = (fan_ev_reg
        & ~(rd_st4_clr & rdata_reg[ST4_FAN])) | fan_edge;
    assign intrusion_next = (intrusion_reg
        & ~(rd_st4_clr & rdata_reg[ST4_INTRUSION])) | ci_sync_reg;
    // write one to clear, set wins
    assign irq_stat_next = (irq_stat_reg
        & ~((wr_b0 & sel_istat) ? wbyte[IRQ_W-1:0] : 4'h0)) | irq_set;

    // ==========================================================
    // two-flop synchronisers; pins start high so status reads zero at reset
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            pin_meta_reg <= '1; // deasserted under the reset polarity
            pin_sync_reg <= '1;
            ci_meta_reg  <= 1'b0;
            ci_sync_reg  <= 1'b0;
            ci_prev_reg  <= 1'b0;
        end else begin
            pin_meta_reg <= gpio_in_i;
            pin_sync_reg <= pin_meta_reg;
            ci_meta_reg  <= chassis_intrusion_i;
            ci_sync_reg  <= ci_meta_reg;
            ci_prev_reg  <= ci_sync_reg;
        end
    end

    // bus handshake: one wait cycle, then answer for one cycle
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            wait_reg  <= 1'b1;
            rdata_reg <= '0;
        end else begin
            wait_reg <= ~(wait_reg & (avm_i.read | avm_i.write));
            if (wait_reg & avm_i.read) begin
                rdata_reg <= {{(DATA_W-8){1'b0}}, rd_byte};
            end
        end
    end

    // configuration and mask registers
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            pincfg1_reg  <= REG8_RESET;
            pincfg2_reg  <= REG8_RESET;
            pin16cfg_reg <= REG8_RESET;
            irq_mask_reg <= '0;
        end else if (wr_b0) begin
            if (sel_cfg1)  pincfg1_reg  <= wbyte;
            if (sel_cfg2)  pincfg2_reg  <= wbyte;
            if (sel_cfg16) pin16cfg_reg <= wbyte;
            if (sel_imask) irq_mask_reg <= wbyte[IRQ_W-1:0];
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            limit_reg     <= '0;
            int_ev_reg    <= 1'b0;
            thermal_limit_mode_ev_reg  <= 1'b0;
            fan_ev_reg    <= 1'b0;
            intrusion_reg <= 1'b0;
            out_bit_reg   <= '0;
        end else begin
            // limits latched at end of conversion
            if (conv_done_i) limit_reg <= monitor_i.out_of_limit;
            int_ev_reg    <= int_ev_next;
            thermal_limit_mode_ev_reg  <= thermal_limit_mode_ev_next;
            fan_ev_reg    <= fan_ev_next;
            intrusion_reg <= intrusion_next;
            out_bit_reg   <= out_bit_next;
        end
    end

    // mode history for edge detection, interrupt and pin drivers
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            int_mode_reg <= 1'b0;
            any_mode_reg <= 1'b0;
            fan_reg      <= 1'b0;
            irq_stat_reg <= '0;
            irq_reg      <= 1'b0;
            gpio_out_reg <= '0;
            gpio_oe_reg  <= '0;
        end else begin
            int_mode_reg <= monitor_i.int_thermal_mode;
            any_mode_reg <= monitor_i.any_thermal_mode;
            fan_reg      <= monitor_i.fan_running;
            irq_stat_reg <= irq_stat_next;
            irq_reg      <= |(irq_stat_reg & irq_mask_reg);
            gpio_out_reg <= out_bit_reg ~^ pin_pol;
            gpio_oe_reg  <= pin_dir;
        end
    end

    assign avm_readdata_o    = rdata_reg;
    assign avm_waitrequest_o = wait_reg;
    assign gpio_out_o        = gpio_out_reg;
    assign gpio_oe_o         = gpio_oe_reg;
    assign irq_o             = irq_reg;

    // ==========================================================
    // assertions
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);

    limit_load_a: assert property (
        conv_done_i |=> limit_reg == $past(monitor_i.out_of_limit))
        else $error("limit bits not loaded at conversion end");

    thermal_limit_mode_event_a: assert property (
        $rose(monitor_i.any_thermal_mode) |=> thermal_limit_mode_ev_reg)
        else $error("thermal engage did not set event bit");

    int_event_a: assert property (
        $fell(monitor_i.int_thermal_mode) |=> st4_view[ST4_INT_TEMP])
        else $error("internal thermal release not flagged");

    fan_event_a: assert property (
        monitor_i.automatic_fan_control && $changed(monitor_i.fan_running)
        |=> fan_ev_reg)
        else $error("fan transition not flagged");

    unused_zero_a: assert property (
        wait_reg && avm_i.read && sel_st4 |=> !rdata_reg[5])
        else $error("unused bit read as one");

    intrusion_latch_a: assert property (
        $rose(ci_sync_reg) |=> intrusion_reg [*2])
        else $error("intrusion not latched");

    pin_input_a: assert property (
        !pin_dir[0] |-> st5_view[0] == (pin_sync_reg[0] ~^ pin_pol[0]))
        else $error("input pin zero status wrong");

    pin_drive_a: assert property (
        wr_b0 && sel_st5 && pin_dir[0] && $stable(pin_pol[0])
    |=> ##1 gpio_out_o[0] == ($past(wbyte[0], 2) ~^ $past(pin_pol[0], 2)))
        else $error("output pin zero not driven");

    readonly_bit_a: assert property (
        wr_b0 && sel_st5 && !pin_dir[2] |=> $stable(out_bit_reg[2]))
        else $error("write landed on input pin");

    irq_level_a: assert property (
        |(irq_stat_reg & irq_mask_reg) |=> irq_o)
        else $error("interrupt not raised");

    thermal_limit_mode_seen_c: cover property ($rose(monitor_i.any_thermal_mode));
    pin_write_c: cover property (wr_b0 && sel_st5 && |pin_dir[7:0]);
    st4_read_c: cover property (rd_done && sel_st4 && intrusion_reg);
    irq_c: cover property ($rose(irq_o));

endmodule : msr_status_regs

// file: verification/msr_host_model.sv
// avalon master model standing in for the management bus host
`timescale 1ns/1ps
module msr_host_model (
    // clock
    input  wire logic                       clk_i,
    // avalon master side
    output msr_pkg::msr_avmm_req_type       req_o,
    input  wire logic [msr_pkg::DATA_W-1:0] readdata_i,
    input  wire logic                       waitrequest_i
);
    import msr_pkg::*;

    // ==========================================================
    // idle bus
    initial req_o = '0;

    // ==========================================================
    // one transfer; the request stands until waitrequest is seen low,
    // and it waits without limit, so the bench watchdog must end a hang
    task automatic bus_cycle(input logic wr,
                             input logic [ADDR_W-1:0] addr,
                             input logic [7:0] wdata,
                             input logic [BE_W-1:0] be,
                             output logic [DATA_W-1:0] rdata);
        @(posedge clk_i);
        req_o.read       <= ~wr;
        req_o.write      <= wr;
        req_o.address    <= addr;
        req_o.writedata  <= {24'h000000, wdata};
        req_o.byteenable <= be;
        // waitrequest is read as it stood just before each rising edge
        do begin
            @(posedge clk_i);
        end while (waitrequest_i !== 1'b0);
        rdata = readdata_i;
        req_o.read  <= 1'b0;
        req_o.write <= 1'b0;
    endtask : bus_cycle

endmodule : msr_host_model

// file: verification/msr_status_regs_test.sv
// self-checking bench of the monitor status registers
`timescale 1ns/1ps
module msr_status_regs_test;
    import msr_pkg::*;

    // ==========================================================
    // signals
    logic                clk;
    logic                reset_n;
    msr_avmm_req_type    avm_req;
    logic [DATA_W-1:0]   readdata;
    logic                waitreq;
    logic                conv_done;
    msr_monitor_type     mon;
    logic                intrusion;
    logic [NUM_PINS-1:0] pin_drv;
    logic [NUM_PINS-1:0] gpio_out;
    logic [NUM_PINS-1:0] gpio_oe;
    wire  [NUM_PINS-1:0] pin_lvl;
    logic                irq;
    int                  err_total;
    int                  n_compared;
    logic [DATA_W-1:0]   scratch;

    // pin wire: the device wins where it drives, the bench elsewhere
    assign pin_lvl = (gpio_oe & gpio_out) | (~gpio_oe & pin_drv);

    // ==========================================================
    // instances
    msr_status_regs i_msr_status_regs (
        .clk_i(clk), .reset_n_i(reset_n), .avm_i(avm_req),
        .avm_readdata_o(readdata), .avm_waitrequest_o(waitreq),
        .conv_done_i(conv_done), .monitor_i(mon),
        .chassis_intrusion_i(intrusion), .gpio_in_i(pin_lvl),
        .gpio_out_o(gpio_out), .gpio_oe_o(gpio_oe), .irq_o(irq));

    msr_host_model i_msr_host_model (
        .clk_i(clk), .req_o(avm_req), .readdata_i(readdata),
        .waitrequest_i(waitreq));

    // ==========================================================
    // clock and watchdog
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // the whole run needs under two hundred cycles; allow over fifteen times that
    initial begin
        repeat (3000) @(posedge clk);
        err_total++;
        close_out();
    end

    // ==========================================================
    // helpers
    task automatic close_out();
        if (err_total == 0 && n_compared > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : close_out

    task automatic check(input string what, input logic [DATA_W-1:0] exp,
                         input logic [DATA_W-1:0] got);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic wr(input logic [5:0] idx, input logic [7:0] data);
        logic [DATA_W-1:0] unused;
        i_msr_host_model.bus_cycle(1'b1, {idx, 2'b00}, data, 4'hF, unused);
    endtask : wr

    task automatic rd(input logic [5:0] idx, input logic [7:0] exp,
                      input string what);
        logic [DATA_W-1:0] got;
        i_msr_host_model.bus_cycle(1'b0, {idx, 2'b00}, 8'h00, 4'hF, got);
        check(what, {24'h000000, exp}, got);
    endtask : rd

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask : tick

    task automatic convert(input logic [LIMIT_W-1:0] lim);
        mon.out_of_limit <= lim;
        @(posedge clk) conv_done <= 1'b1;
        @(posedge clk) conv_done <= 1'b0;
    endtask : convert

    // ==========================================================
    // test sequence
    initial begin
        err_total = 0;
        n_compared = 0;
        reset_n = 1'b0;
        conv_done = 1'b0;
        mon = '0;
        intrusion = 1'b0;
        pin_drv = '1; // idle pins deasserted under default active-low
        tick(10);
        reset_n <= 1'b1;
        rd(IDX_STATUS4, 8'h00, "status4 reset");
        rd(IDX_STATUS5, 8'h00, "status5 reset");
        // limit bits follow only the last conversion
        convert(3'b111);
        rd(IDX_STATUS4, 8'h07, "limits all");
        convert(3'b010);
        mon.out_of_limit <= 3'b101;
        tick(3);
        rd(IDX_STATUS4, 8'h02, "limits held");
        convert(3'b101);
        rd(IDX_STATUS4, 8'h05, "limits new");
        convert(3'b000);
        rd(IDX_STATUS4, 8'h00, "limits clear");
        // thermal flags, one per edge, not per level
        mon.any_thermal_mode <= 1'b1;
        tick(3);
        rd(IDX_STATUS4, 8'h08, "any engage");
        mon.int_thermal_mode <= 1'b1;
        tick(3);
        rd(IDX_STATUS4, 8'h01, "int engage");
        rd(IDX_STATUS4, 8'h00, "level held");
        mon.any_thermal_mode <= 1'b0;
        mon.int_thermal_mode <= 1'b0;
        tick(3);
        rd(IDX_STATUS4, 8'h09, "release");
        // fan flag only counts in automatic mode
        mon.fan_running <= 1'b1;
        tick(3);
        mon.fan_running <= 1'b0;
        tick(3);
        rd(IDX_STATUS4, 8'h00, "fan manual");
        mon.automatic_fan_control <= 1'b1;
        tick(2);
        mon.fan_running <= 1'b1;
        tick(3);
        rd(IDX_STATUS4, 8'h10, "fan on");
        rd(IDX_STATUS4, 8'h00, "fan once");
        mon.fan_running <= 1'b0;
        tick(3);
        rd(IDX_STATUS4, 8'h10, "fan off");
        // interrupt masked, then intrusion enabled
        @(negedge clk);
        check("irq masked", 32'h0, {31'h0, irq});
        wr(IDX_IRQ_MASK, 8'h08);
        rd(IDX_IRQ_MASK, 8'h08, "irq mask");
        // lane zero disabled: the write must be dropped
        i_msr_host_model.bus_cycle(1'b1, {IDX_IRQ_MASK, 2'b00}, 8'hFF,
                                   4'hE, scratch);
        rd(IDX_IRQ_MASK, 8'h08, "mask lane off");
        intrusion <= 1'b1;
        tick(3);
        intrusion <= 1'b0;
        tick(4);
        @(negedge clk);
        check("irq raised", 32'h1, {31'h0, irq});
        rd(IDX_STATUS4, 8'h40, "intrusion");
        rd(IDX_IRQ_STAT, 8'h0F, "irq status");
        wr(IDX_IRQ_STAT, 8'h0F);
        rd(IDX_IRQ_STAT, 8'h00, "irq cleared");
        // pins: 0 out high, 1 out low, 2 in high, 3 in low, 4-5 high 6-7 low
        pin_drv <= 9'b1_0101_1100;
        @(negedge clk);
        check("irq low", 32'h0, {31'h0, irq});
        wr(IDX_PINCFG1, 8'h27);
        wr(IDX_PINCFG2, 8'h0A);
        wr(IDX_PIN16CFG, 8'h02);
        @(negedge clk);
        check("pin dir", 32'h3, {23'h0, gpio_oe});
        rd(IDX_STATUS4, 8'h80, "pin16 in");
        wr(IDX_STATUS4, 8'h00);
        rd(IDX_STATUS4, 8'h80, "pin16 ro");
        wr(IDX_STATUS5, 8'hFF);
        rd(IDX_STATUS5, 8'h97, "pins set");
        @(negedge clk);
        check("drive set", 32'h1, {30'h0, gpio_out[1:0]});
        wr(IDX_STATUS5, 8'h00);
        rd(IDX_STATUS5, 8'h94, "pins clr");
        @(negedge clk);
        check("drive clr", 32'h2, {30'h0, gpio_out[1:0]});
        wr(IDX_PIN16CFG, 8'h00);
        rd(IDX_STATUS4, 8'h00, "pin16 low act");
        // pin sixteen as active-low output
        wr(IDX_PIN16CFG, 8'h01);
        wr(IDX_STATUS4, 8'hFF);
        tick(2);
        @(negedge clk);
        check("pin16 on", 32'h2, {30'h0, gpio_oe[8], gpio_out[8]});
        rd(IDX_STATUS4, 8'h80, "pin16 out");
        wr(IDX_STATUS4, 8'h00);
        tick(2);
        @(negedge clk);
        check("pin16 off", 32'h3, {30'h0, gpio_oe[8], gpio_out[8]});
        // unmapped place reads zero and ignores writes
        wr(6'h01, 8'hFF);
        rd(6'h01, 8'h00, "unmapped");
        close_out();
    end

endmodule : msr_status_regs_test
